// ==== pkg/iod_pkg.sv ====
// Package for the I/O register space decoder: map, access kinds, fields.
// Assumes one core clock and an active-low asynchronous reset.
package iod_pkg;
    localparam int unsigned IOD_DW = 8;
    localparam int unsigned IOD_IO_AW = 6;
    localparam int unsigned IOD_DS_AW = 8;
    localparam int unsigned IOD_NREG = 64;
    localparam logic [IOD_DS_AW-1:0] IOD_DS_OFFSET = 8'h20;
    localparam logic [IOD_DS_AW-1:0] IOD_EXT_LO = 8'h60;
    localparam logic [IOD_IO_AW-1:0] IOD_BIT_LAST = 6'h1F;
    localparam logic [IOD_DW-1:0] IOD_ZERO = 8'h00;

    // Register offsets (I/O addresses)
    localparam logic [IOD_IO_AW-1:0] IOD_PORT_B_PIN_INPUT = 6'h03;
    localparam logic [IOD_IO_AW-1:0] IOD_PORT_B_DIRECTION = 6'h04;
    localparam logic [IOD_IO_AW-1:0] IOD_PORT_B_OUTPUT = 6'h05;
    localparam logic [IOD_IO_AW-1:0] IOD_PORT_C_PIN_INPUT = 6'h06;
    localparam logic [IOD_IO_AW-1:0] IOD_PORT_C_DIRECTION = 6'h07;
    localparam logic [IOD_IO_AW-1:0] IOD_PORT_C_OUTPUT = 6'h08;
    localparam logic [IOD_IO_AW-1:0] IOD_PORT_D_PIN_INPUT = 6'h09;
    localparam logic [IOD_IO_AW-1:0] IOD_PORT_D_DIRECTION = 6'h0A;
    localparam logic [IOD_IO_AW-1:0] IOD_PORT_D_OUTPUT = 6'h0B;
    localparam logic [IOD_IO_AW-1:0] IOD_PORT_A_PIN_INPUT = 6'h0C;
    localparam logic [IOD_IO_AW-1:0] IOD_PORT_A_DIRECTION = 6'h0D;
    localparam logic [IOD_IO_AW-1:0] IOD_PORT_A_OUTPUT = 6'h0E;
    localparam logic [IOD_IO_AW-1:0] IOD_PORT_PULLUP_AND_DRIVE_CONTROL = 6'h12;
    localparam logic [IOD_IO_AW-1:0] IOD_TIMER0_INTERRUPT_FLAGS = 6'h15;
    localparam logic [IOD_IO_AW-1:0] IOD_TIMER1_INTERRUPT_FLAGS = 6'h16;
    localparam logic [IOD_IO_AW-1:0] IOD_GENERAL_SCRATCH_0 = 6'h1E;
    localparam logic [IOD_IO_AW-1:0] IOD_EEPROM_CONTROL = 6'h1F;
    localparam logic [IOD_IO_AW-1:0] IOD_EEPROM_DATA = 6'h20;
    localparam logic [IOD_IO_AW-1:0] IOD_EEPROM_ADDRESS_LOW = 6'h21;
    localparam logic [IOD_IO_AW-1:0] IOD_GLOBAL_TIMER_CONTROL = 6'h23;
    localparam logic [IOD_IO_AW-1:0] IOD_TIMER0_CONTROL = 6'h25;
    localparam logic [IOD_IO_AW-1:0] IOD_TIMER0_COUNT_VALUE = 6'h26;
    localparam logic [IOD_IO_AW-1:0] IOD_TIMER0_COMPARE_A = 6'h27;
    localparam logic [IOD_IO_AW-1:0] IOD_TIMER0_COMPARE_B = 6'h28;
    localparam logic [IOD_IO_AW-1:0] IOD_GENERAL_SCRATCH_1 = 6'h2A;

    // Implemented-bit masks; everything else reads zero
    localparam logic [IOD_DW-1:0] IOD_MASK_PORT_A = 8'h0F;
    localparam logic [IOD_DW-1:0] IOD_MASK_TIMER0_INTERRUPT_FLAGS = 8'h07;
    localparam logic [IOD_DW-1:0] IOD_MASK_TIMER1_INTERRUPT_FLAGS = 8'h27;
    localparam logic [IOD_DW-1:0] IOD_MASK_EECTRL = 8'h3F;
    localparam logic [IOD_DW-1:0] IOD_MASK_GTCTRL = 8'h81;
    localparam logic [IOD_DW-1:0] IOD_MASK_T0CTRL = 8'h0F;
    localparam logic [IOD_DW-1:0] IOD_MASK_FULL = 8'hFF;

    // Per-register kind
    typedef enum logic [1:0] {
        IOD_K_NONE = 2'h0,
        IOD_K_RW = 2'h1,
        IOD_K_RO = 2'h2,
        IOD_K_W1C = 2'h3
    } iod_kind_t;

    // Core access operations
    typedef enum logic [2:0] {
        IOD_OP_IDLE = 3'h0,
        IOD_OP_IO_IN = 3'h1,
        IOD_OP_IO_OUT = 3'h2,
        IOD_OP_LOAD = 3'h3,
        IOD_OP_STORE = 3'h4,
        IOD_OP_SET_BIT = 3'h5,
        IOD_OP_CLR_BIT = 3'h6,
        IOD_OP_TEST_BIT = 3'h7
    } iod_op_t;

    // Status register bits in the core's own register block
    localparam int unsigned IOD_EV_REFUSED = 0;
    localparam int unsigned IOD_EV_DONE = 1;
    localparam int unsigned IOD_NEV = 2;

    // Controller APB register offsets
    localparam logic [7:0] IOD_A_CMD = 8'h00;
    localparam logic [7:0] IOD_A_RESULT = 8'h04;
    localparam logic [7:0] IOD_A_STATUS = 8'h08;
    localparam logic [7:0] IOD_A_IRQ_EN = 8'h0C;
    localparam logic [7:0] IOD_A_IRQ_CLR = 8'h10;
    // Command and result word fields
    localparam int unsigned IOD_C_ADDR_LSB = 0;
    localparam int unsigned IOD_C_DATA_LSB = 8;
    localparam int unsigned IOD_C_BIT_LSB = 16;
    localparam int unsigned IOD_C_OP_LSB = 20;
    localparam int unsigned IOD_R_SKIP = 8;
    localparam int unsigned IOD_R_REFUSED = 9;
endpackage

// ==== pkg/iod_if.sv ====
// Interface between the core-side controller and the I/O space decoder.
// Assumes both ends share pclk; one request, one-cycle strobe.
`timescale 1ns/10ps
interface iod_if (
    input wire logic pclk,
    input wire logic presetn
);
    import iod_pkg::*;
    logic req;
    iod_op_t op;
    logic [IOD_DS_AW-1:0] addr;
    logic [2:0] bit_sel;
    logic [IOD_DW-1:0] wdata;
    logic ack;
    logic [IOD_DW-1:0] rdata;
    logic bit_val;
    logic refused;

    modport dev (
        input pclk, presetn, req, op, addr, bit_sel, wdata,
        output ack, rdata, bit_val, refused
    );
    modport core (
        input pclk, presetn, ack, rdata, bit_val, refused,
        output req, op, addr, bit_sel, wdata
    );
endinterface

// ==== verilog/iod_space.sv ====
// I/O register space decoder: 64 I/O locations, data-space mirror, bit ops.
// Assumes the core raises req for one cycle; answer comes the next cycle.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
module iod_space
    import iod_pkg::*;
#(
    parameter int unsigned EXT_WORDS = 160
) (
    iod_if.dev bus,
    input wire logic [IOD_DW-1:0] port_a_pins,
    input wire logic [IOD_DW-1:0] port_b_pins,
    input wire logic [IOD_DW-1:0] port_c_pins,
    input wire logic [IOD_DW-1:0] port_d_pins,
    input wire logic [IOD_DW-1:0] t0_flag_set,
    input wire logic [IOD_DW-1:0] t1_flag_set,
    output logic [IOD_DW-1:0] port_b_dir,
    output logic [IOD_DW-1:0] port_b_out
);
    initial begin
        if (EXT_WORDS != 160) $error("iod_space: extended area is 0x60-0xFF");
    end

    logic [IOD_DW-1:0] regs_ff [IOD_NREG];
    logic [IOD_DW-1:0] ext_ff [EXT_WORDS];
    logic [IOD_DW-1:0] mask [IOD_NREG];
    iod_kind_t kind [IOD_NREG];
    logic [IOD_DW-1:0] rd_view [IOD_NREG];
    logic [IOD_DW-1:0] nxt_rdata;
    logic nxt_bit_val;
    logic nxt_refused;
    logic [IOD_IO_AW-1:0] io_a;
    logic in_io;
    logic in_ext;
    logic is_bitop;
    logic do_wr;
    logic [IOD_DW-1:0] bit_mask;
    logic ack_ff;
    logic [IOD_DW-1:0] rdata_ff;
    logic bit_val_ff;
    logic refused_ff;

    // Register map: kind and implemented bits per location
    always_comb begin
        for (int i = 0; i < IOD_NREG; i++) begin
            kind[i] = IOD_K_NONE;
            mask[i] = IOD_ZERO;
        end
        kind[IOD_PORT_B_PIN_INPUT] = IOD_K_RO; mask[IOD_PORT_B_PIN_INPUT] = IOD_MASK_FULL;
        kind[IOD_PORT_C_PIN_INPUT] = IOD_K_RO; mask[IOD_PORT_C_PIN_INPUT] = IOD_MASK_FULL;
        kind[IOD_PORT_D_PIN_INPUT] = IOD_K_RO; mask[IOD_PORT_D_PIN_INPUT] = IOD_MASK_FULL;
        kind[IOD_PORT_A_PIN_INPUT] = IOD_K_RO; mask[IOD_PORT_A_PIN_INPUT] = IOD_MASK_PORT_A;
        kind[IOD_PORT_B_DIRECTION] = IOD_K_RW; mask[IOD_PORT_B_DIRECTION] = IOD_MASK_FULL;
        kind[IOD_PORT_B_OUTPUT] = IOD_K_RW; mask[IOD_PORT_B_OUTPUT] = IOD_MASK_FULL;
        kind[IOD_PORT_C_DIRECTION] = IOD_K_RW; mask[IOD_PORT_C_DIRECTION] = IOD_MASK_FULL;
        kind[IOD_PORT_C_OUTPUT] = IOD_K_RW; mask[IOD_PORT_C_OUTPUT] = IOD_MASK_FULL;
        kind[IOD_PORT_D_DIRECTION] = IOD_K_RW; mask[IOD_PORT_D_DIRECTION] = IOD_MASK_FULL;
        kind[IOD_PORT_D_OUTPUT] = IOD_K_RW; mask[IOD_PORT_D_OUTPUT] = IOD_MASK_FULL;
        kind[IOD_PORT_A_DIRECTION] = IOD_K_RW; mask[IOD_PORT_A_DIRECTION] = IOD_MASK_PORT_A;
        kind[IOD_PORT_A_OUTPUT] = IOD_K_RW; mask[IOD_PORT_A_OUTPUT] = IOD_MASK_PORT_A;
        kind[IOD_PORT_PULLUP_AND_DRIVE_CONTROL] = IOD_K_RW;
        mask[IOD_PORT_PULLUP_AND_DRIVE_CONTROL] = IOD_MASK_FULL;
        kind[IOD_TIMER0_INTERRUPT_FLAGS] = IOD_K_W1C; mask[IOD_TIMER0_INTERRUPT_FLAGS] = IOD_MASK_TIMER0_INTERRUPT_FLAGS;
        kind[IOD_TIMER1_INTERRUPT_FLAGS] = IOD_K_W1C; mask[IOD_TIMER1_INTERRUPT_FLAGS] = IOD_MASK_TIMER1_INTERRUPT_FLAGS;
        kind[IOD_GENERAL_SCRATCH_0] = IOD_K_RW; mask[IOD_GENERAL_SCRATCH_0] = IOD_MASK_FULL;
        kind[IOD_EEPROM_CONTROL] = IOD_K_RW; mask[IOD_EEPROM_CONTROL] = IOD_MASK_EECTRL;
        kind[IOD_EEPROM_DATA] = IOD_K_RW; mask[IOD_EEPROM_DATA] = IOD_MASK_FULL;
        kind[IOD_EEPROM_ADDRESS_LOW] = IOD_K_RW; mask[IOD_EEPROM_ADDRESS_LOW] = IOD_MASK_FULL;
        kind[IOD_GLOBAL_TIMER_CONTROL] = IOD_K_RW; mask[IOD_GLOBAL_TIMER_CONTROL] = IOD_MASK_GTCTRL;
        kind[IOD_TIMER0_CONTROL] = IOD_K_RW; mask[IOD_TIMER0_CONTROL] = IOD_MASK_T0CTRL;
        kind[IOD_TIMER0_COUNT_VALUE] = IOD_K_RW; mask[IOD_TIMER0_COUNT_VALUE] = IOD_MASK_FULL;
        kind[IOD_TIMER0_COMPARE_A] = IOD_K_RW; mask[IOD_TIMER0_COMPARE_A] = IOD_MASK_FULL;
        kind[IOD_TIMER0_COMPARE_B] = IOD_K_RW; mask[IOD_TIMER0_COMPARE_B] = IOD_MASK_FULL;
        kind[IOD_GENERAL_SCRATCH_1] = IOD_K_RW; mask[IOD_GENERAL_SCRATCH_1] = IOD_MASK_FULL;
    end

    // Address decode by operation
    always_comb begin
        is_bitop = bus.op inside {IOD_OP_SET_BIT, IOD_OP_CLR_BIT, IOD_OP_TEST_BIT};
        in_io = 1'b0;
        in_ext = 1'b0;
        io_a = bus.addr[IOD_IO_AW-1:0];
        nxt_refused = 1'b0;
        case (bus.op)
            IOD_OP_IO_IN, IOD_OP_IO_OUT: begin
                // High address bits set means outside 0x00-0x3F
                in_io = bus.addr[IOD_DS_AW-1:IOD_IO_AW] == 2'h0;
                nxt_refused = !in_io;
            end
            IOD_OP_LOAD, IOD_OP_STORE: begin
                io_a = IOD_IO_AW'(bus.addr - IOD_DS_OFFSET);
                in_io = bus.addr >= IOD_DS_OFFSET && bus.addr < IOD_EXT_LO;
                in_ext = bus.addr >= IOD_EXT_LO;
                nxt_refused = !in_io && !in_ext;
            end
            IOD_OP_SET_BIT, IOD_OP_CLR_BIT, IOD_OP_TEST_BIT: begin
                in_io = bus.addr <= IOD_DS_AW'(IOD_BIT_LAST);
                nxt_refused = !in_io;
            end
            default: begin
                nxt_refused = 1'b0;
            end
        endcase
        do_wr = bus.req && in_io &&
            bus.op inside {IOD_OP_IO_OUT, IOD_OP_STORE, IOD_OP_SET_BIT, IOD_OP_CLR_BIT};
        bit_mask = IOD_DW'(1) << bus.bit_sel;
    end

    // Per-register storage; hardware flag set wins over a software clear
    genvar g;
    generate
        for (g = 0; g < IOD_NREG; g++) begin : g_reg
            logic hit;
            logic [IOD_DW-1:0] hw_set;
            logic [IOD_DW-1:0] nxt_val;
            assign hit = do_wr && io_a == IOD_IO_AW'(g);
            assign hw_set = (g == IOD_TIMER0_INTERRUPT_FLAGS) ? t0_flag_set :
                (g == IOD_TIMER1_INTERRUPT_FLAGS) ? t1_flag_set : IOD_ZERO;
            always_comb begin
                nxt_val = regs_ff[g];
                if (hit) begin
                    case (kind[g])
                        IOD_K_RW: begin
                            if (is_bitop) begin
                                // Only the addressed bit changes
                                nxt_val = (bus.op == IOD_OP_SET_BIT) ?
                                    (regs_ff[g] | bit_mask) : (regs_ff[g] & ~bit_mask);
                            end else begin
                                nxt_val = bus.wdata;
                            end
                        end
                        IOD_K_W1C: begin
                            // Bit ops touch one flag only; clear-bit writes no ones
                            if (is_bitop) begin
                                nxt_val = (bus.op == IOD_OP_SET_BIT) ?
                                    (regs_ff[g] & ~bit_mask) : regs_ff[g];
                            end else begin
                                nxt_val = regs_ff[g] & ~bus.wdata;
                            end
                        end
                        default: begin
                            nxt_val = regs_ff[g];
                        end
                    endcase
                end
                nxt_val = (nxt_val | hw_set) & mask[g];
            end
            always_ff @(posedge bus.pclk or negedge bus.presetn) begin
                if (!bus.presetn) begin
                    regs_ff[g] <= IOD_ZERO;
                end else begin
                    regs_ff[g] <= nxt_val;
                end
            end
        end
    endgenerate

    // Pin inputs read live; stored values elsewhere
    always_comb begin
        for (int i = 0; i < IOD_NREG; i++) begin
            rd_view[i] = regs_ff[i] & mask[i];
        end
        rd_view[IOD_PORT_A_PIN_INPUT] = port_a_pins & IOD_MASK_PORT_A;
        rd_view[IOD_PORT_B_PIN_INPUT] = port_b_pins;
        rd_view[IOD_PORT_C_PIN_INPUT] = port_c_pins;
        rd_view[IOD_PORT_D_PIN_INPUT] = port_d_pins;
    end

    // Extended area: plain load/store storage
    always_ff @(posedge bus.pclk) begin
        if (bus.req && in_ext && bus.op == IOD_OP_STORE) begin
            ext_ff[bus.addr - IOD_EXT_LO] <= bus.wdata;
        end
    end

    always_comb begin
        nxt_rdata = IOD_ZERO;
        if (in_io) begin
            nxt_rdata = rd_view[io_a];
        end else if (in_ext) begin
            nxt_rdata = ext_ff[bus.addr - IOD_EXT_LO];
        end
        nxt_bit_val = in_io && is_bitop && nxt_rdata[bus.bit_sel];
    end

    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn) begin
            ack_ff <= 1'b0;
            rdata_ff <= IOD_ZERO;
            bit_val_ff <= 1'b0;
            refused_ff <= 1'b0;
        end else begin
            ack_ff <= bus.req;
            if (bus.req) begin
                rdata_ff <= nxt_rdata;
                bit_val_ff <= nxt_bit_val;
                refused_ff <= nxt_refused;
            end
        end
    end

    assign bus.ack = ack_ff;
    assign bus.rdata = rdata_ff;
    assign bus.bit_val = bit_val_ff;
    assign bus.refused = refused_ff;
    assign port_b_dir = regs_ff[IOD_PORT_B_DIRECTION];
    assign port_b_out = regs_ff[IOD_PORT_B_OUTPUT];
endmodule // iod_space

// ==== verilog/iod_core.sv ====
// Core-side end: takes commands over APB and issues I/O space accesses.
// Assumes one pclk domain shared with the decoder.
`timescale 1ns/10ps
module iod_core
    import iod_pkg::*;
(
    iod_if.core bus,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    typedef enum logic [1:0] {
        IOD_S_IDLE = 2'b00,
        IOD_S_ISSUE = 2'b01,
        IOD_S_WAIT = 2'b11
    } iod_state_t;

    iod_state_t state_ff;
    logic [31:0] cmd_ff;
    logic [9:0] result_ff;
    logic [IOD_NEV-1:0] status_ff;
    logic [IOD_NEV-1:0] irq_en_ff;
    logic [IOD_NEV-1:0] ev;
    logic wr;
    logic [IOD_DW-1:0] wr_addr;
    iod_op_t cmd_op;

    assign wr = psel && penable && pwrite;
    assign wr_addr = paddr;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign cmd_op = iod_op_t'(cmd_ff[IOD_C_OP_LSB +: 3]);

    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn) begin
            state_ff <= IOD_S_IDLE;
            cmd_ff <= 32'h0000_0000;
        end else begin
            case (state_ff)
                IOD_S_IDLE: begin
                    // Commands written while busy are dropped
                    if (wr && wr_addr == IOD_A_CMD) begin
                        cmd_ff <= pwdata;
                        state_ff <= IOD_S_ISSUE;
                    end
                end
                IOD_S_ISSUE: state_ff <= IOD_S_WAIT;
                IOD_S_WAIT: begin
                    if (bus.ack) begin
                        state_ff <= IOD_S_IDLE;
                    end
                end
                default: state_ff <= IOD_S_IDLE;
            endcase
        end
    end

    // Reserved-bit and reserved-address hygiene is up to software
    assign bus.req = state_ff == IOD_S_ISSUE;
    assign bus.op = cmd_op;
    assign bus.addr = cmd_ff[IOD_C_ADDR_LSB +: IOD_DS_AW];
    assign bus.wdata = cmd_ff[IOD_C_DATA_LSB +: IOD_DW];
    assign bus.bit_sel = cmd_ff[IOD_C_BIT_LSB +: 3];

    assign ev[IOD_EV_DONE] = state_ff == IOD_S_WAIT && bus.ack;
    assign ev[IOD_EV_REFUSED] = state_ff == IOD_S_WAIT && bus.ack && bus.refused;

    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn) begin
            result_ff <= 10'h000;
        end else if (ev[IOD_EV_DONE]) begin
            result_ff <= {bus.refused, bus.bit_val, bus.rdata};
        end
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge bus.pclk or negedge bus.presetn) begin
        if (!bus.presetn) begin
            status_ff <= '0;
            irq_en_ff <= '0;
        end else begin
            if (wr && wr_addr == IOD_A_IRQ_EN) begin
                irq_en_ff <= pwdata[IOD_NEV-1:0];
            end
            if (wr && wr_addr == IOD_A_IRQ_CLR) begin
                status_ff <= (status_ff & ~pwdata[IOD_NEV-1:0]) | ev;
            end else begin
                status_ff <= status_ff | ev;
            end
        end
    end

    assign irq = |(status_ff & irq_en_ff);

    always_comb begin
        prdata = 32'h0000_0000;
        case (paddr)
            IOD_A_CMD: prdata = {cmd_ff[31:2], state_ff};
            IOD_A_RESULT: prdata = {22'h000000, result_ff};
            IOD_A_STATUS: prdata = {30'h00000000, status_ff};
            IOD_A_IRQ_EN: prdata = {30'h00000000, irq_en_ff};
            default: prdata = 32'h0000_0000;
        endcase
    end
endmodule // iod_core

// ==== verif/iod_assertions.sv ====
// Checker on the link between the core-side controller and the decoder.
// Assumes the signals of one iod_if, one clock, active-low reset.
`timescale 1ns/10ps
module iod_assertions
    import iod_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req,
    input wire iod_op_t op,
    input wire logic [IOD_DS_AW-1:0] addr,
    input wire logic [2:0] bit_sel,
    input wire logic [IOD_DW-1:0] wdata,
    input wire logic ack,
    input wire logic [IOD_DW-1:0] rdata,
    input wire logic bit_val,
    input wire logic refused
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_io_req;
        req && (op == IOD_OP_IO_IN || op == IOD_OP_IO_OUT);
    endsequence
    sequence s_mem_req;
        req && (op == IOD_OP_LOAD || op == IOD_OP_STORE);
    endsequence
    sequence s_bit_req;
        req && (op == IOD_OP_SET_BIT || op == IOD_OP_CLR_BIT || op == IOD_OP_TEST_BIT);
    endsequence
    sequence s_answer(r);
        ack && (refused == r);
    endsequence

    a_ack_timing: assert property (req |=> ack) else $error("no answer one cycle after request");
    a_ack_cause: assert property (ack |-> $past(req)) else $error("answer without a request");
    a_ack_pulse: assert property (ack |=> !ack) else $error("answer held longer than a cycle");
    a_io_refuse: assert property (s_io_req ##0 (addr > 8'h3F) |=> s_answer(1'b1))
        else $error("I/O access above 0x3F accepted");
    a_io_accept: assert property (s_io_req ##0 (addr <= 8'h3F) |=> s_answer(1'b0))
        else $error("I/O access in range refused");
    a_mem_low: assert property (s_mem_req ##0 (addr < IOD_DS_OFFSET) |=> s_answer(1'b1))
        else $error("data access below the I/O offset accepted");
    a_mem_accept: assert property (s_mem_req ##0 (addr >= IOD_DS_OFFSET) |=> s_answer(1'b0))
        else $error("data access in range refused");
    a_bit_refuse: assert property (s_bit_req ##0 (addr > 8'h1F) |=> s_answer(1'b1))
        else $error("bit access above 0x1F accepted");
    a_bit_accept: assert property (s_bit_req ##0 (addr <= 8'h1F) |=> s_answer(1'b0))
        else $error("bit access in range refused");
    a_rsvd_zero: assert property (req && op == IOD_OP_IO_IN && addr <= 8'h02 |=>
        ack && rdata == IOD_ZERO) else $error("reserved location read nonzero");
    a_rdata_hold: assert property (!ack |-> $stable(rdata)) else $error("read data moved without answer");
endmodule // iod_assertions

// ==== verif/tb_top.sv ====
// Bench for the controller and the decoder joined through iod_if.
// Assumes APB access to the controller and a 50 MHz clock.
`timescale 1ns/10ps
module tb_top;
    import iod_pkg::*;
    localparam logic [31:0] M_RD = 32'h000002FF;
    localparam logic [31:0] M_RF = 32'h00000200;
    localparam logic [31:0] M_BV = 32'h00000300;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr, port_a_pins, port_b_pins, port_c_pins, port_d_pins;
    logic [7:0] t0_flag_set, t1_flag_set, port_b_dir, port_b_out;
    logic [31:0] pwdata, prdata, q;
    int error_cnt, checked;

    iod_if iod_if_i (.pclk(pclk), .presetn(presetn));
    iod_core iod_core_i (.bus(iod_if_i.core), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq));
    iod_space iod_space_i (.bus(iod_if_i.dev), .port_a_pins(port_a_pins),
        .port_b_pins(port_b_pins), .port_c_pins(port_c_pins), .port_d_pins(port_d_pins),
        .t0_flag_set(t0_flag_set), .t1_flag_set(t1_flag_set), .port_b_dir(port_b_dir),
        .port_b_out(port_b_out));
    iod_assertions iod_assertions_i (.pclk(pclk), .presetn(presetn), .req(iod_if_i.req),
        .op(iod_if_i.op), .addr(iod_if_i.addr), .bit_sel(iod_if_i.bit_sel),
        .wdata(iod_if_i.wdata), .ack(iod_if_i.ack), .rdata(iod_if_i.rdata),
        .bit_val(iod_if_i.bit_val), .refused(iod_if_i.refused));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            error_cnt++;
            $display("unexpected pready: expected 1, seen %b", pready);
        end
    endtask

    // Issues one access, waits for done, compares the masked result word
    task automatic run(input iod_op_t op, input logic [7:0] a, input logic [7:0] d,
            input logic [2:0] b, input logic [31:0] exp, input logic [31:0] m);
        logic [31:0] r;
        int n;
        apb(1'b1, IOD_A_CMD, {9'h000, op, 1'b0, b, d, a}, r);
        n = 0;
        do begin
            apb(1'b0, IOD_A_STATUS, 32'h00000000, r);
            n++;
        end while (r[IOD_EV_DONE] !== 1'b1 && n < 20);
        // A command that never completes must not slip through as a pass
        if (r[IOD_EV_DONE] !== 1'b1) begin
            error_cnt++;
            $display("unexpected done: expected 1, seen %b", r[IOD_EV_DONE]);
        end
        apb(1'b0, IOD_A_RESULT, 32'h00000000, r);
        chk("result", r & m, exp);
        apb(1'b1, IOD_A_IRQ_CLR, 32'h00000003, r);
    endtask

    task automatic results();
        $display("checks %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        results();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {t0_flag_set, t1_flag_set} = 16'h0000;
        port_a_pins = 8'hFF;
        port_b_pins = 8'h3C;
        port_c_pins = 8'h81;
        port_d_pins = 8'h5A;
        error_cnt = 0;
        checked = 0;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, IOD_A_STATUS, 32'h00000000, q);
        chk("status", q, 32'h00000000);
        apb(1'b0, 8'h20, 32'h00000000, q);
        chk("unmapped", q, 32'h00000000);
        chk("slverr", {31'h00000000, pslverr}, 32'h00000000);
        chk("dir", {24'h000000, port_b_dir}, 32'h00000000);
        $display("test reset done");
        // Map: I/O and data-space views of the same register
        run(IOD_OP_IO_OUT, 8'h04, 8'hA5, 3'h0, 32'h00000000, M_RF);
        chk("dir", {24'h000000, port_b_dir}, 32'h000000A5);
        run(IOD_OP_LOAD, 8'h24, 8'h00, 3'h0, 32'h000000A5, M_RD);
        run(IOD_OP_STORE, 8'h25, 8'h3C, 3'h0, 32'h00000000, M_RF);
        chk("out", {24'h000000, port_b_out}, 32'h0000003C);
        run(IOD_OP_IO_IN, 8'h05, 8'h00, 3'h0, 32'h0000003C, M_RD);
        run(IOD_OP_IO_IN, 8'h09, 8'h00, 3'h0, 32'h0000005A, M_RD);
        run(IOD_OP_IO_IN, 8'h40, 8'h00, 3'h0, M_RF, M_RF);
        run(IOD_OP_LOAD, 8'h1F, 8'h00, 3'h0, M_RF, M_RF);
        run(IOD_OP_STORE, 8'h80, 8'h5A, 3'h0, 32'h00000000, M_RF);
        run(IOD_OP_LOAD, 8'h80, 8'h00, 3'h0, 32'h0000005A, M_RD);
        run(IOD_OP_IO_OUT, 8'h60, 8'h11, 3'h0, M_RF, M_RF);
        $display("test map done");
        // Bit access: range, single-bit effect, tests of every bit
        run(IOD_OP_SET_BIT, 8'h04, 8'h00, 3'h1, 32'h00000000, M_RF);
        run(IOD_OP_CLR_BIT, 8'h04, 8'h00, 3'h0, 32'h00000000, M_RF);
        chk("dir", {24'h000000, port_b_dir}, 32'h000000A6);
        run(IOD_OP_SET_BIT, 8'h20, 8'h00, 3'h0, M_RF, M_RF);
        run(IOD_OP_CLR_BIT, 8'h3F, 8'h00, 3'h0, M_RF, M_RF);
        run(IOD_OP_TEST_BIT, 8'h20, 8'h00, 3'h0, M_RF, M_RF);
        for (int i = 0; i < 8; i++) begin
            run(IOD_OP_TEST_BIT, 8'h06, 8'h00, i[2:0], {23'h000000, port_c_pins[i], 8'h00}, M_BV);
        end
        $display("test bits done");
        // Flags cleared by writing one; bit ops touch only their bit
        // Writes carry zero in reserved bit positions
        @(posedge pclk);
        t0_flag_set <= 8'h07;
        t1_flag_set <= 8'h27;
        @(posedge pclk);
        t0_flag_set <= 8'h00;
        t1_flag_set <= 8'h00;
        run(IOD_OP_IO_IN, 8'h15, 8'h00, 3'h0, 32'h00000007, M_RD);
        run(IOD_OP_SET_BIT, 8'h15, 8'h00, 3'h1, 32'h00000000, M_RF);
        run(IOD_OP_CLR_BIT, 8'h15, 8'h00, 3'h0, 32'h00000000, M_RF);
        run(IOD_OP_IO_IN, 8'h15, 8'h00, 3'h0, 32'h00000005, M_RD);
        run(IOD_OP_IO_OUT, 8'h15, 8'h04, 3'h0, 32'h00000000, M_RF);
        run(IOD_OP_IO_IN, 8'h15, 8'h00, 3'h0, 32'h00000001, M_RD);
        run(IOD_OP_IO_OUT, 8'h16, 8'h27, 3'h0, 32'h00000000, M_RF);
        run(IOD_OP_IO_IN, 8'h16, 8'h00, 3'h0, 32'h00000000, M_RD);
        $display("test flags done");
        // Reserved places read zero; they are only ever read, never written
        run(IOD_OP_IO_IN, 8'h02, 8'h00, 3'h0, 32'h00000000, M_RD);
        run(IOD_OP_IO_IN, 8'h29, 8'h00, 3'h0, 32'h00000000, M_RD);
        run(IOD_OP_IO_IN, 8'h0C, 8'h00, 3'h0, 32'h0000000F, M_RD);
        $display("test reserved done");
        // Interrupt on a refused access: raise, mask, clear
        apb(1'b1, IOD_A_IRQ_EN, 32'h00000001, q);
        apb(1'b1, IOD_A_CMD, {9'h000, IOD_OP_IO_IN, 4'h0, 8'h00, 8'h40}, q);
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        chk("irq", {31'h00000000, irq}, 32'h00000001);
        apb(1'b1, IOD_A_IRQ_EN, 32'h00000000, q);
        @(negedge pclk);
        chk("irq", {31'h00000000, irq}, 32'h00000000);
        apb(1'b1, IOD_A_IRQ_EN, 32'h00000001, q);
        apb(1'b1, IOD_A_IRQ_CLR, 32'h00000001, q);
        @(negedge pclk);
        chk("irq", {31'h00000000, irq}, 32'h00000000);
        apb(1'b0, IOD_A_STATUS, 32'h00000000, q);
        chk("status", q & 32'h00000001, 32'h00000000);
        $display("test irq done");
        results();
    end
endmodule // tb_top
